// file: inc/ssp_pkg.sv
/*
 * Shared constants and types of the synchronous serial port pin and select logic.
 * Assumes a 100 MHz system clock; imported whole by the design module.
 */
package ssp_pkg;

	// ==========================================================================
	// Byte framing
	// ==========================================================================
	localparam int         SSP_BYTE_BITS = 8;
	localparam int         SSP_MSB       = SSP_BYTE_BITS - 1;
	localparam logic [2:0] SSP_FIRST_BIT = 3'h0;
	localparam logic [2:0] SSP_LAST_BIT  = 3'h7;

	// ==========================================================================
	// Select-mode field encodings and bit positions
	// ==========================================================================
	localparam logic [1:0] SSP_SEL_3WIRE = 2'h0;
	localparam logic [1:0] SSP_SEL_4W_IN = 2'h1;
	localparam int         SSP_SEL_HIGH  = 1;
	localparam int         SSP_SEL_LOW   = 0;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int SSP_CLK_MHZ      = 100;
	localparam int SSP_SCK_HALF_NS  = 40;
	localparam int SSP_SCK_HALF_CYC = (SSP_SCK_HALF_NS * SSP_CLK_MHZ) / 1000;
	localparam int SSP_HCNT_W       = 8;

	// ==========================================================================
	// Master sequencer states
	// ==========================================================================
	typedef enum logic [1:0] {
		SSP_M_IDLE,
		SSP_M_LOW,
		SSP_M_HIGH
	} ssp_mstate_t;

endpackage : ssp_pkg

// file: rtl/ssp_pin_select.sv
/*
 * Pin direction, select-mode handling and byte shifting of a synchronous serial
 * port that works as bus master (system clock, divided serial clock) or slave
 * (serial clock from the pin, a domain of its own).
 * Assumes control bits arrive as plain system-clock ports and that the
 * testbench resolves the three-signal pins into wires.
 */
`timescale 1ns/1ns

module ssp_pin_select
	import ssp_pkg::*;
#(
	parameter int SCK_HALF = SSP_SCK_HALF_CYC
)(
	input  wire logic       mclk_in,
	input  wire logic       reset_n_in,
	input  wire logic       sck_in,
	input  wire logic [1:0] select_mode_field_in,
	input  wire logic       port_enable_set_in,
	input  wire logic       port_enable_clr_in,
	input  wire logic       master_enable_set_in,
	input  wire logic       master_enable_clr_in,
	input  wire logic       mode_fault_clr_in,
	input  wire logic       transfer_done_clr_in,
	input  wire logic       tx_write_in,
	input  wire logic [7:0] tx_data_in,
	input  wire logic       mosi_in,
	input  wire logic       miso_in,
	input  wire logic       nss_in,
	output logic            port_enable_bit_out,
	output logic            master_enable_bit_out,
	output logic            mode_fault_flag_out,
	output logic            transfer_done_flag_out,
	output logic            busy_out,
	output logic [7:0]      rx_data_out,
	output logic            mosi_out,
	output logic            mosi_oe_out,
	output logic            miso_out,
	output logic            miso_oe_out,
	output logic            sck_out,
	output logic            sck_oe_out,
	output logic            nss_out,
	output logic            nss_oe_out,
	output logic            nss_mapped_out
);

	// ==========================================================================
	// Declarations
	// ==========================================================================
	logic                  port_en;
	logic                  master_en;
	logic                  mode_fault;
	logic                  xfer_done;
	logic [7:0]            rx_data;
	logic [7:0]            tx_hold;
	logic                  nss_level;
	logic                  nss_m1;
	logic                  nss_s2;
	logic                  nss_s3;
	logic                  miso_m1;
	logic                  miso_s2;
	ssp_mstate_t           mstate;
	ssp_mstate_t           next_mstate;
	logic [SSP_HCNT_W-1:0] hcnt;
	logic [2:0]            mbit;
	logic [7:0]            mshift;
	logic [7:0]            mrecv;
	logic [2:0]            sbit;
	logic [7:0]            sshift;
	logic [7:0]            srecv;
	logic                  sdone_tgl;
	logic                  tgl_m1;
	logic                  tgl_s2;
	logic                  tgl_s3;

	// ==========================================================================
	// Mode decode
	// ==========================================================================
	// Role and select-mode terms shared by the pins and the sequencers.
	wire mode_3wire   = (select_mode_field_in == SSP_SEL_3WIRE);
	wire mode_4w_in   = (select_mode_field_in == SSP_SEL_4W_IN);
	wire mode_out     = select_mode_field_in[SSP_SEL_HIGH];
	wire master_run   = port_en & master_en;
	wire slave_run    = port_en & ~master_en;
	wire nss_fall     = nss_s3 & ~nss_s2;
	wire fault_event  = master_run & mode_4w_in & nss_fall;
	wire half_end     = (hcnt == SSP_HCNT_W'(SCK_HALF - 1));
	wire last_mbit    = (mbit == SSP_LAST_BIT);
	wire start_master = master_run & tx_write_in & (mstate == SSP_M_IDLE);
	wire master_done  = (mstate == SSP_M_HIGH) & half_end & last_mbit;
	wire slave_done   = tgl_s2 ^ tgl_s3;
	wire slave_sel    = mode_3wire | (mode_4w_in & ~nss_s2);

	// Slave logic runs only as an enabled, selected slave; a high select input
	// holds it cleared in select-input mode, and the two output modes always do, so clock pulses are ignored and the counter restarts.
	wire slave_clr_n  = reset_n_in & slave_run & slave_sel;

	// ==========================================================================
	// Pin drive
	// ==========================================================================
	// Data line directions follow the role; data bits come from flops.
	assign mosi_oe_out    = master_run;
	assign mosi_out       = mshift[SSP_MSB];
	assign miso_oe_out    = slave_run & slave_sel;
	assign miso_out       = (sbit == SSP_FIRST_BIT) ? tx_hold[SSP_MSB]
	                                                 : sshift[SSP_MSB];
	assign sck_oe_out     = master_run;
	assign sck_out        = (mstate == SSP_M_HIGH);
	assign nss_oe_out     = port_en & mode_out;
	assign nss_out        = nss_level;
	assign nss_mapped_out = ~mode_3wire;

	// Status and control outputs straight from their registers; busy_out decodes mstate.
	assign port_enable_bit_out    = port_en;
	assign master_enable_bit_out  = master_en;
	assign mode_fault_flag_out    = mode_fault;
	assign transfer_done_flag_out = xfer_done;
	assign rx_data_out            = rx_data;
	assign busy_out               = (mstate != SSP_M_IDLE);

	// ==========================================================================
	// Input synchronisers (system clock)
	// ==========================================================================
	// Select and slave-to-master pins, and the byte-done toggle of the serial clock
	// domain, pass two flops; the third flops of select and toggle find edges.
	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			nss_m1  <= 1'b1;
			nss_s2  <= 1'b1;
			nss_s3  <= 1'b1;
			miso_m1 <= 1'b0;
			miso_s2 <= 1'b0;
			tgl_m1  <= 1'b0;
			tgl_s2  <= 1'b0;
			tgl_s3  <= 1'b0;
		end
		else
		begin
			nss_m1  <= nss_in;
			nss_s2  <= nss_m1;
			nss_s3  <= nss_s2;
			miso_m1 <= miso_in;
			miso_s2 <= miso_m1;
			tgl_m1  <= sdone_tgl;
			tgl_s2  <= tgl_m1;
			tgl_s3  <= tgl_s2;
		end
	end

	// ==========================================================================
	// Control bits and flags
	// ==========================================================================
	// Enables are set and cleared by software; a mode fault clears both.
	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			port_en   <= 1'b0;
			master_en <= 1'b0;
		end
		else if (fault_event)
		begin
			port_en   <= 1'b0;
			master_en <= 1'b0;
		end
		else
		begin
			port_en   <= port_enable_set_in | (port_en & ~port_enable_clr_in);
			master_en <= master_enable_set_in | (master_en & ~master_enable_clr_in);
		end
	end

	// Sticky flags: a set in the same cycle as a clear wins.
	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			mode_fault <= 1'b0;
			xfer_done  <= 1'b0;
		end
		else
		begin
			mode_fault <= fault_event | (mode_fault & ~mode_fault_clr_in);
			xfer_done  <= master_done | (slave_done & slave_run)
			            | (xfer_done & ~transfer_done_clr_in);
		end
	end

	// Select output level tracks the field low bit one clock later.
	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			nss_level <= 1'b1;
		else
			nss_level <= select_mode_field_in[SSP_SEL_LOW];
	end

	// Received byte from whichever role finished; slave write fills tx_hold.
	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rx_data <= 8'h00;
			tx_hold <= 8'h00;
		end
		else
		begin
			if (master_done)
				rx_data <= mrecv;
			else if (slave_done & slave_run)
				rx_data <= srecv;
			if (tx_write_in & ~master_run)
				tx_hold <= tx_data_in;
		end
	end

	// ==========================================================================
	// Master sequencer (system clock, divided serial clock)
	// ==========================================================================
	// Low half presents the bit, rising edge samples, high half then shifts.
	always_comb
	begin
		next_mstate = mstate;
		unique case (mstate)
			SSP_M_IDLE:
				if (start_master)
					next_mstate = SSP_M_LOW;
			SSP_M_LOW:
				if (half_end)
					next_mstate = SSP_M_HIGH;
			SSP_M_HIGH:
				if (half_end)
					next_mstate = last_mbit ? SSP_M_IDLE : SSP_M_LOW;
		endcase
		if (!master_run || fault_event)
			next_mstate = SSP_M_IDLE;
	end

	// State and half-period counter.
	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			mstate <= SSP_M_IDLE;
			hcnt   <= '0;
		end
		else
		begin
			mstate <= next_mstate;
			hcnt   <= (half_end || mstate == SSP_M_IDLE) ? '0 : hcnt + 1'b1;
		end
	end

	// Master shift and receive registers, MSB first both ways.
	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			mshift <= 8'h00;
			mrecv  <= 8'h00;
			mbit   <= SSP_FIRST_BIT;
		end
		else if (start_master)
		begin
			mshift <= tx_data_in;
			mbit   <= SSP_FIRST_BIT;
		end
		else if (mstate == SSP_M_LOW && half_end)
			mrecv <= {mrecv[SSP_MSB-1:0], miso_s2};
		else if (mstate == SSP_M_HIGH && half_end && !last_mbit)
		begin
			mshift <= {mshift[SSP_MSB-1:0], 1'b0};
			mbit   <= mbit + 1'b1;
		end
	end

	// ==========================================================================
	// Slave shifter (serial clock domain)
	// ==========================================================================
	// Sample on each rising edge; bit 0 loads the waiting byte behind it.
	// The waiting byte must be written while no slave byte is in flight.
	always_ff @(posedge sck_in or negedge slave_clr_n)
	begin
		if (!slave_clr_n)
		begin
			sbit   <= SSP_FIRST_BIT;
			sshift <= 8'h00;
		end
		else
		begin
			sbit   <= sbit + 1'b1;
			if (sbit == SSP_FIRST_BIT)
				sshift <= {tx_hold[SSP_MSB-1:0], mosi_in};
			else
				sshift <= {sshift[SSP_MSB-1:0], mosi_in};
		end
	end

	// Eighth edge captures the byte and flips the done toggle. These flops
	// keep their value across a clear so the system side sees each toggle.
	always_ff @(posedge sck_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			srecv     <= 8'h00;
			sdone_tgl <= 1'b0;
		end
		else if (slave_clr_n && sbit == SSP_LAST_BIT)
		begin
			srecv     <= {sshift[SSP_MSB-1:0], mosi_in};
			sdone_tgl <= ~sdone_tgl;
		end
	end

endmodule : ssp_pin_select

// file: verification/ssp_checker.sv
/* Assertions on the serial port pin and select logic.
   Bound to ssp_pin_select; sees its ports only. */
`timescale 1ns/1ns
module ssp_checker
	import ssp_pkg::*;
#(
	parameter int SCK_HALF = SSP_SCK_HALF_CYC
)(
	input wire logic       mclk_in,
	input wire logic       reset_n_in,
	input wire logic [1:0] select_mode_field_in,
	input wire logic       tx_write_in,
	input wire logic [7:0] tx_data_in,
	input wire logic       nss_in,
	input wire logic       port_enable_bit_out,
	input wire logic       master_enable_bit_out,
	input wire logic       mode_fault_flag_out,
	input wire logic       transfer_done_flag_out,
	input wire logic       busy_out,
	input wire logic       mosi_out,
	input wire logic       mosi_oe_out,
	input wire logic       miso_oe_out,
	input wire logic       nss_out,
	input wire logic       nss_mapped_out
);
	// ==========
	// Helpers
	localparam int DONE_LO = 16 * SCK_HALF - 9;
	localparam int DONE_HI = 16 * SCK_HALF - 6;
	// Master role, accepted byte start and select-input mode.
	wire logic mst = port_enable_bit_out && master_enable_bit_out;
	wire logic go  = tx_write_in && mst && !busy_out;
	wire logic m01 = select_mode_field_in == SSP_SEL_4W_IN;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!reset_n_in);
	sequence m_start;
		go;
	endsequence
	sequence m_byte;
		busy_out[*8] ##[DONE_LO:DONE_HI] transfer_done_flag_out;
	endsequence
	// ==========
	// Assertions
	mosi_dir_a: assert property (mosi_oe_out == mst)
		else $error("mosi enable wrong");
	miso_dir_a: assert property (miso_oe_out |-> port_enable_bit_out && !master_enable_bit_out)
		else $error("miso driven out of role");
	nss_map_a: assert property (nss_mapped_out == (select_mode_field_in != SSP_SEL_3WIRE))
		else $error("select mapping wrong");
	nss_level_a: assert property ($past(reset_n_in) && select_mode_field_in[SSP_SEL_HIGH]
		|-> nss_out == $past(select_mode_field_in[SSP_SEL_LOW])) else $error("select level wrong");
	unsel_a: assert property ((m01 && nss_in)[*5] |-> !miso_oe_out)
		else $error("unselected slave drives miso");
	three_a: assert property ((port_enable_bit_out && !master_enable_bit_out
		&& select_mode_field_in == SSP_SEL_3WIRE)[*3] |-> miso_oe_out) else $error("miso not driven");
	fault_a: assert property ($fell(nss_in) && m01 && mst |-> ##[1:5]
		(mode_fault_flag_out && !port_enable_bit_out && !master_enable_bit_out)) else $error("no fault");
	mosi_first_a: assert property (m_start |=> busy_out && mosi_out == $past(tx_data_in[SSP_MSB]))
		else $error("first bit wrong");
	master_done_a: assert property (disable iff (!reset_n_in || mode_fault_flag_out)
		m_start |=> m_byte) else $error("byte end wrong");
endmodule : ssp_checker

// file: verification/ssp_far_end.sv
/* Far-end device: a slave answering the port as master, and a master
   whose clock is the link clock gated to frames.
   Assumes the testbench resolves every pin from both drivers. */
`timescale 1ns/1ns
module ssp_far_end (
	input  wire logic lclk_in,
	input  wire logic sck_in,
	input  wire logic mosi_in,
	input  wire logic miso_in,
	input  wire logic nss_in,
	output logic      sck_out,
	output logic      mosi_out,
	output logic      miso_out,
	output logic      nss_out
);
	// ==========
	// Slave role, the only slave on the bus.
	logic [7:0] sh;
	logic [7:0] srx;
	// Sample on the rising clock, shift on the falling one.
	always @(posedge sck_in) srx <= {srx[6:0], mosi_in};
	always @(negedge sck_in) if (!nss_in) sh <= {sh[6:0], ~sh[7]};
	// Unselected, the line shows the inverse of the bit it would carry.
	assign miso_out = nss_in ? ~sh[7] : sh[7];
	// ==========
	// Master role
	initial
	begin
		sck_out = 1'b0;
		mosi_out = 1'b0;
		nss_out = 1'b1;
	end
	task automatic load(input logic [7:0] b);
		sh = b;
	endtask : load
	task automatic grab(input logic lvl);
		nss_out <= lvl;
	endtask : grab
	// Up to one byte, MSB first; the clock runs only inside the frame.
	task automatic xfer(input logic [7:0] b, input logic sel, output logic [7:0] got,
		input int nbits);
		@(posedge lclk_in);
		nss_out <= !sel;
		repeat (3) @(posedge lclk_in);
		for (int i = 7; i > 7 - nbits; i--)
		begin
			@(negedge lclk_in);
			sck_out <= 1'b0;
			mosi_out <= b[i];
			@(posedge lclk_in);
			got[i] = miso_in;
			sck_out <= 1'b1;
		end
		@(negedge lclk_in);
		sck_out <= 1'b0;
		mosi_out <= ~mosi_out;
		repeat (2) @(posedge lclk_in);
		nss_out <= 1'b1;
	endtask : xfer
endmodule : ssp_far_end

// file: verification/tb.sv
/* Self-checking bench: master and slave bytes, select modes, mode fault.
   Assumes the far-end model and the checker files are compiled first. */
`timescale 1ns/1ns
module tb
	import ssp_pkg::*;
;
	localparam int HALF = 3;
	logic       mclk = 1'b0;
	logic       lclk = 1'b0;
	logic       reset_n = 1'b0;
	logic [1:0] field = 2'h0;
	logic [6:0] pls = 7'h00;
	logic [7:0] tx = 8'h00;
	logic [7:0] got, rx;
	logic       pe, me, mf, td, busy, mo, mo_oe, so, so_oe, ck, ck_oe, ns, ns_oe, map;
	logic       f_ck, f_mo, f_so, f_ns;
	int         mismatches = 0;
	int         check_count = 0;
	// Each pin carries whichever party enables it.
	wire mosi = mo_oe ? mo : f_mo;
	wire miso = so_oe ? so : f_so;
	wire sck  = ck_oe ? ck : f_ck;
	wire nss  = ns_oe ? ns : f_ns;
	// System clock, and a link clock of its own period.
	always #5 mclk = ~mclk;
	always #6 lclk = ~lclk;
	// Pulses: port set, clear, master set, clear, fault clear, done clear, write.
	ssp_pin_select #(.SCK_HALF(HALF)) u_dut (
		.mclk_in(mclk), .reset_n_in(reset_n), .sck_in(sck), .select_mode_field_in(field),
		.port_enable_set_in(pls[6]), .port_enable_clr_in(pls[5]),
		.master_enable_set_in(pls[4]), .master_enable_clr_in(pls[3]),
		.mode_fault_clr_in(pls[2]), .transfer_done_clr_in(pls[1]), .tx_write_in(pls[0]),
		.tx_data_in(tx), .mosi_in(mosi), .miso_in(miso), .nss_in(nss),
		.port_enable_bit_out(pe), .master_enable_bit_out(me), .mode_fault_flag_out(mf),
		.transfer_done_flag_out(td), .busy_out(busy), .rx_data_out(rx), .mosi_out(mo),
		.mosi_oe_out(mo_oe), .miso_out(so), .miso_oe_out(so_oe), .sck_out(ck),
		.sck_oe_out(ck_oe), .nss_out(ns), .nss_oe_out(ns_oe), .nss_mapped_out(map)
	);
	ssp_far_end u_far (
		.lclk_in(lclk), .sck_in(sck), .mosi_in(mosi), .miso_in(miso), .nss_in(nss),
		.sck_out(f_ck), .mosi_out(f_mo), .miso_out(f_so), .nss_out(f_ns)
	);
	// ==========
	// Shared tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic ctl(input logic [6:0] p);
		@(posedge mclk);
		pls <= p;
		@(posedge mclk);
		pls <= 7'h00;
		#1;
	endtask : ctl
	task automatic wait_done();
		int n = 0;
		while (td !== 1'b1 && n < 400)
		begin
			@(posedge mclk);
			n++;
		end
		#1;
	endtask : wait_done
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	// ==========
	// Scenarios
	task automatic t_map();
		for (int f = 0; f < 4; f++)
		begin
			@(posedge mclk);
			field <= f[1:0];
			@(posedge mclk);
			#1;
			check(map, 8'(f != 0));
		end
	endtask : t_map
	task automatic t_master();
		u_far.load(8'h96);
		@(posedge mclk);
		field <= 2'h2;
		tx <= 8'hA5;
		ctl(7'h50);
		check({ns_oe, ns, mo_oe, so_oe}, 8'h0A);
		ctl(7'h01);
		check({busy, ck_oe}, 8'h03);
		wait_done();
		check(rx, 8'h96);
		check(u_far.srx, 8'hA5);
		@(posedge mclk);
		field <= 2'h3;
		@(posedge mclk);
		#1;
		check(ns, 8'h01);
		ctl(7'h02);
	endtask : t_master
	task automatic t_slave3();
		@(posedge mclk);
		field <= SSP_SEL_3WIRE;
		tx <= 8'h3C;
		ctl(7'h08);
		ctl(7'h01);
		check({me, mo_oe, ck_oe, so_oe}, 8'h01);
		u_far.xfer(8'h5A, 1'b0, got, 8);
		wait_done();
		check(rx, 8'h5A);
		check(got, 8'h3C);
		ctl(7'h22);
		check({pe, so_oe, td}, 8'h00);
	endtask : t_slave3
	task automatic t_slave4();
		@(posedge mclk);
		field <= SSP_SEL_4W_IN;
		tx <= 8'h81;
		ctl(7'h41);
		u_far.xfer(8'hFF, 1'b0, got, 8);
		u_far.xfer(8'hF0, 1'b1, got, 3);
		repeat (8) @(posedge mclk);
		#1;
		check({td, so_oe, mo_oe, ck_oe}, 8'h00);
		u_far.xfer(8'hC3, 1'b1, got, 8);
		wait_done();
		check(rx, 8'hC3);
		check(got, 8'h81);
		ctl(7'h02);
	endtask : t_slave4
	task automatic t_fault();
		ctl(7'h10);
		ctl(7'h01);
		u_far.grab(1'b0);
		repeat (8) @(posedge mclk);
		#1;
		check({pe, me, mf}, 8'h01);
		ctl(7'h04);
		check(mf, 8'h00);
		u_far.grab(1'b1);
	endtask : t_fault
	// Main sequence after a reset of 16 cycles.
	initial
	begin
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		#1;
		check({pe, me, mf, td, mo_oe, so_oe, ns_oe, ns}, 8'h01);
		t_map();
		t_master();
		t_slave3();
		t_slave4();
		t_fault();
		stop_test();
	end
	// Watchdog far beyond the expected run.
	initial
	begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		stop_test();
	end
endmodule : tb

bind ssp_pin_select ssp_checker #(.SCK_HALF(SCK_HALF)) u_chk (
	.mclk_in, .reset_n_in, .select_mode_field_in, .tx_write_in, .tx_data_in, .nss_in,
	.port_enable_bit_out, .master_enable_bit_out, .mode_fault_flag_out,
	.transfer_done_flag_out, .busy_out, .mosi_out, .mosi_oe_out, .miso_oe_out,
	.nss_out, .nss_mapped_out
);
